// ==== gpp_pkg.sv ====
`default_nettype none
package gpp_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_FSEL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FSEL_SET  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FSEL_CLR  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OE        = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_OE_SET    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_OE_CLR    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_OUT       = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_OUT_SET   = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_OUT_CLR   = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IN        = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_MODE      = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_POL       = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_INCON     = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_IEN       = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_IEN_SET   = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_IEN_CLR   = 8'h3c;
   localparam logic [ADDR_W-1:0] OFS_PEND      = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_PEND_CLR  = 8'h48;
   localparam logic [ADDR_W-1:0] OFS_WAKE      = 8'h4c;
   localparam logic [ADDR_W-1:0] OFS_WAKE_SET  = 8'h50;
   localparam logic [ADDR_W-1:0] OFS_WAKE_CLR  = 8'h54;
   localparam logic [ADDR_W-1:0] OFS_DUAL      = 8'h5c;
   // reset values
   localparam logic [DATA_W-1:0] RST_ONES      = 32'hffffffff;
   localparam logic [DATA_W-1:0] RST_ZERO      = 32'h00000000;
endpackage : gpp_pkg
`default_nettype wire

// ==== gpp_port.sv ====
// Operation
// - function select never touches input or irq path
// - function select resets to all ones
// - function select set alias sets ones
// - function select clear alias clears ones
// - output enable bit drives pin
// - output enable set alias sets ones
// - output enable clear alias clears ones
// - output data drives level, resets zero
// - output data set alias sets ones
// - output data clear alias clears ones
// - input reads pin only when connected
// - input connect gates readback, resets ones
// - mode bit picks level or edge
// - level polarity selects low or high
// - edge polarity selects falling or rising
// - enable gates request, keeps pending status
// - irq enable set alias sets ones
// - irq enable clear alias clears ones
// - pending status reads one when pending
// - write one to clear pending bit
// - wake enable marks pin as wake source
// - wake enable set alias sets ones
// - status set regardless of enable, irq gated
// - clearing pending re-arms edge detector
// - dual edge triggers both edges
// - wake only from edge events
//
// Decided for this implementation: the Wishbone slave port.
`default_nettype none
module gpp_port
   import gpp_pkg::*;
#(
   parameter int unsigned PINS = 32
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [gpp_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [gpp_pkg::DATA_W-1:0] wb_dat_i,
   output logic      [gpp_pkg::DATA_W-1:0] wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic [PINS-1:0]           pin_in_i,
   output logic      [PINS-1:0]           pin_out_o,
   output logic      [PINS-1:0]           pin_oe_o,
   output logic      [PINS-1:0]           function_select_o,
   output logic                           irq_o,
   output logic      [PINS-1:0]           wake_event_o
);
   import gpp_pkg::*;

   initial begin
      if (PINS == 0 || PINS > DATA_W) begin
         $error("gpp_port: PINS must be 1..32");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   logic              ack_reg;
   logic [DATA_W-1:0] rdat_reg;
   logic [DATA_W-1:0] wmask;
   wire               acc   = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire               wr    = acc & wb_we_i;
   wire  [DATA_W-1:0] wdat  = wb_dat_i & wmask;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
      hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
   endfunction : hit

   // byte lanes not selected are left alone
   function automatic logic [PINS-1:0] upd(input logic [PINS-1:0] cur,
                                           input logic            w_plain,
                                           input logic            w_set,
                                           input logic            w_clr,
                                           input logic [PINS-1:0] d,
                                           input logic [PINS-1:0] m);
      logic [PINS-1:0] v;
      v = cur;
      if (w_plain) begin
         v = (cur & ~m) | (d & m);
      end
      if (w_set) begin
         v = v | d;
      end
      if (w_clr) begin
         v = v & ~d;
      end
      upd = v;
   endfunction : upd

   wire [PINS-1:0] wd = wdat[PINS-1:0];
   wire [PINS-1:0] wm = wmask[PINS-1:0];

   ////////////////////////////////////////////////////////////////////////
   // write strobes, one per writable register or alias
   // low address bits are ignored, so a byte offset inside a word hits that word
   // function select
   wire wr_fsel     = wr & hit(wb_adr_i, OFS_FSEL);
   wire wr_fsel_set = wr & hit(wb_adr_i, OFS_FSEL_SET);
   wire wr_fsel_clr = wr & hit(wb_adr_i, OFS_FSEL_CLR);
   // output enable and output data
   wire wr_oe       = wr & hit(wb_adr_i, OFS_OE);
   wire wr_oe_set   = wr & hit(wb_adr_i, OFS_OE_SET);
   wire wr_oe_clr   = wr & hit(wb_adr_i, OFS_OE_CLR);
   wire wr_out      = wr & hit(wb_adr_i, OFS_OUT);
   wire wr_out_set  = wr & hit(wb_adr_i, OFS_OUT_SET);
   wire wr_out_clr  = wr & hit(wb_adr_i, OFS_OUT_CLR);
   // input and interrupt configuration
   wire wr_mode     = wr & hit(wb_adr_i, OFS_MODE);
   wire wr_pol      = wr & hit(wb_adr_i, OFS_POL);
   wire wr_incon    = wr & hit(wb_adr_i, OFS_INCON);
   wire wr_ien      = wr & hit(wb_adr_i, OFS_IEN);
   wire wr_ien_set  = wr & hit(wb_adr_i, OFS_IEN_SET);
   wire wr_ien_clr  = wr & hit(wb_adr_i, OFS_IEN_CLR);
   wire wr_pend_clr = wr & hit(wb_adr_i, OFS_PEND_CLR);
   // wake and dual edge
   wire wr_wake     = wr & hit(wb_adr_i, OFS_WAKE);
   wire wr_wake_set = wr & hit(wb_adr_i, OFS_WAKE_SET);
   wire wr_wake_clr = wr & hit(wb_adr_i, OFS_WAKE_CLR);
   wire wr_dual     = wr & hit(wb_adr_i, OFS_DUAL);

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [PINS-1:0] fsel_reg;
   logic [PINS-1:0] oe_reg;
   logic [PINS-1:0] out_reg;
   logic [PINS-1:0] mode_reg;
   logic [PINS-1:0] pol_reg;
   logic [PINS-1:0] incon_reg;
   logic [PINS-1:0] ien_reg;
   logic [PINS-1:0] wake_reg;
   logic [PINS-1:0] dual_reg;
   logic [PINS-1:0] pend_reg;
   logic [PINS-1:0] fsel_next;
   logic [PINS-1:0] oe_next;
   logic [PINS-1:0] out_next;
   logic [PINS-1:0] mode_next;
   logic [PINS-1:0] pol_next;
   logic [PINS-1:0] incon_next;
   logic [PINS-1:0] ien_next;
   logic [PINS-1:0] wake_next;
   logic [PINS-1:0] dual_next;
   logic [PINS-1:0] pend_next;

   // plain writes honour byte lanes; aliases act only on written ones
   assign fsel_next  = upd(fsel_reg, wr_fsel, wr_fsel_set, wr_fsel_clr, wd, wm);
   assign oe_next    = upd(oe_reg, wr_oe, wr_oe_set, wr_oe_clr, wd, wm);
   assign out_next   = upd(out_reg, wr_out, wr_out_set, wr_out_clr, wd, wm);
   assign mode_next  = upd(mode_reg, wr_mode, 1'b0, 1'b0, wd, wm);
   assign pol_next   = upd(pol_reg, wr_pol, 1'b0, 1'b0, wd, wm);
   assign incon_next = upd(incon_reg, wr_incon, 1'b0, 1'b0, wd, wm);
   assign ien_next   = upd(ien_reg, wr_ien, wr_ien_set, wr_ien_clr, wd, wm);
   assign wake_next  = upd(wake_reg, wr_wake, wr_wake_set, wr_wake_clr, wd, wm);
   assign dual_next  = upd(dual_reg, wr_dual, 1'b0, 1'b0, wd, wm);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fsel_reg <= RST_ONES[PINS-1:0];
      end else begin
         fsel_reg <= fsel_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_reg <= RST_ZERO[PINS-1:0];
      end else begin
         oe_reg <= oe_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_reg <= RST_ZERO[PINS-1:0];
      end else begin
         out_reg <= out_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= RST_ZERO[PINS-1:0];
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pol_reg <= RST_ZERO[PINS-1:0];
      end else begin
         pol_reg <= pol_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         incon_reg <= RST_ONES[PINS-1:0];
      end else begin
         incon_reg <= incon_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ien_reg <= RST_ZERO[PINS-1:0];
      end else begin
         ien_reg <= ien_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_reg <= RST_ZERO[PINS-1:0];
      end else begin
         wake_reg <= wake_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dual_reg <= RST_ZERO[PINS-1:0];
      end else begin
         dual_reg <= dual_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input synchroniser and event detection
   // pins may be asynchronous; the detectors read only sync2 and its delayed copy prev_reg
   logic [PINS-1:0] sync1_reg;
   logic [PINS-1:0] sync2_reg;
   logic [PINS-1:0] prev_reg;
   logic [PINS-1:0] armed_reg;
   logic [PINS-1:0] armed_next;
   logic [PINS-1:0] trig;
   logic [PINS-1:0] edge_hit;
   wire  [PINS-1:0] clr_w = wr_pend_clr ? wd : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= RST_ZERO[PINS-1:0];
         sync2_reg <= RST_ZERO[PINS-1:0];
         prev_reg  <= RST_ZERO[PINS-1:0];
      end else begin
         sync1_reg <= pin_in_i;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // detection uses the synchronised pin, not function select or output state
   generate
      for (genvar p = 0; p < PINS; p++) begin : g_det
         wire rise = sync2_reg[p] & ~prev_reg[p];
         wire fall = ~sync2_reg[p] & prev_reg[p];
         wire lvl  = pol_reg[p] ? sync2_reg[p] : ~sync2_reg[p];
         wire edg  = dual_reg[p] ? (rise | fall) : (pol_reg[p] ? rise : fall);
         assign edge_hit[p] = edg & armed_reg[p];
         assign trig[p]     = mode_reg[p] ? edge_hit[p] : lvl;
         // once an edge is caught the detector waits for a clear
         assign armed_next[p] = clr_w[p] ? 1'b1 : (edge_hit[p] & mode_reg[p] ? 1'b0 : armed_reg[p]);
      end
   endgenerate

   // set wins over clear; status records the event regardless of enable
   assign pend_next = (pend_reg & ~clr_w) | trig;

   // level mode re-sets pending every cycle while the level holds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= RST_ZERO[PINS-1:0];
      end else begin
         pend_reg <= pend_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_reg <= RST_ONES[PINS-1:0];
      end else begin
         armed_reg <= armed_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux
   logic [PINS-1:0] rsel;
   wire  [PINS-1:0] in_lvl = sync2_reg & incon_reg;

   // read strobes; aliases have none, so reading them touches nothing
   wire rd_fsel  = hit(wb_adr_i, OFS_FSEL);
   wire rd_oe    = hit(wb_adr_i, OFS_OE);
   wire rd_out   = hit(wb_adr_i, OFS_OUT);
   wire rd_in    = hit(wb_adr_i, OFS_IN);
   wire rd_mode  = hit(wb_adr_i, OFS_MODE);
   wire rd_pol   = hit(wb_adr_i, OFS_POL);
   wire rd_incon = hit(wb_adr_i, OFS_INCON);
   wire rd_ien   = hit(wb_adr_i, OFS_IEN);
   wire rd_pend  = hit(wb_adr_i, OFS_PEND);
   wire rd_wake  = hit(wb_adr_i, OFS_WAKE);
   wire rd_dual  = hit(wb_adr_i, OFS_DUAL);

   always_comb begin
      rsel = '0;  // aliases and unmapped read zero
      if (rd_fsel)  rsel = fsel_reg;
      if (rd_oe)    rsel = oe_reg;
      if (rd_out)   rsel = out_reg;
      if (rd_in)    rsel = in_lvl;
      if (rd_mode)  rsel = mode_reg;
      if (rd_pol)   rsel = pol_reg;
      if (rd_incon) rsel = incon_reg;
      if (rd_ien)   rsel = ien_reg;
      if (rd_pend)  rsel = pend_reg;
      if (rd_wake)  rsel = wake_reg;
      if (rd_dual)  rsel = dual_reg;
   end

   // ack_reg blocks a second take, so every request gets one pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc;
      end
   end

   // data is zero outside ack so a stray sample shows nothing stale
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_reg <= RST_ZERO;
      end else begin
         rdat_reg <= (acc & ~wb_we_i) ? DATA_W'(rsel) : RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   logic            irq_reg;
   logic [PINS-1:0] wake_reg_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(pend_reg & ien_reg);
      end
   end

   // level events never wake: they need the clock running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_reg_o <= RST_ZERO[PINS-1:0];
      end else begin
         wake_reg_o <= wake_reg & mode_reg & pend_reg;
      end
   end

   assign wb_ack_o          = ack_reg;
   assign wb_dat_o          = rdat_reg;
   assign pin_oe_o          = oe_reg;
   assign pin_out_o         = out_reg & oe_reg;
   assign function_select_o = fsel_reg;
   assign irq_o             = irq_reg;
   assign wake_event_o      = wake_reg_o;
endmodule : gpp_port
`default_nettype wire

// ==== gpp_port_monitor.sv ====
`default_nettype none
module gpp_port_monitor
   import gpp_pkg::*;
#(
   parameter int unsigned PINS = 32
) (
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_we_i,
   input wire logic [DATA_W-1:0]   wb_dat_o,
   input wire logic                wb_ack_o,
   input wire logic [PINS-1:0]     pin_out_o,
   input wire logic [PINS-1:0]     pin_oe_o,
   input wire logic [PINS-1:0]     function_select_o,
   input wire logic                irq_o,
   input wire logic [PINS-1:0]     wake_event_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // write lands on the ack edge, so pin_oe_o, pin_out_o and function_select_o move in the ack cycle
   sequence wr_ack;
      wb_ack_o && wb_we_i;
   endsequence
   ack_latency_a: assert property (bus_req |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == RST_ZERO)
      else $error("read data outside ack");
   out_gated_a: assert property ((pin_out_o & ~pin_oe_o) == '0)
      else $error("pin driven while disabled");
   oe_write_a: assert property ($changed(pin_oe_o) |-> wr_ack)
      else $error("output enable moved without write");
   fsel_write_a: assert property ($changed(function_select_o) |-> wr_ack)
      else $error("function select moved without write");
   out_write_a: assert property ($changed(pin_out_o) |-> wr_ack)
      else $error("pin level moved without write");
   irq_clear_a: assert property ($fell(irq_o) |-> $past(wb_ack_o))
      else $error("irq dropped without write");
   reset_out_a: assert property ($fell(rst_i) |-> function_select_o == RST_ONES && pin_oe_o == '0
      && wake_event_o == '0) else $error("bad state after reset");
endmodule : gpp_port_monitor
bind gpp_port gpp_port_monitor #(.PINS(PINS)) i_gpp_port_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
   .function_select_o(function_select_o), .irq_o(irq_o), .wake_event_o(wake_event_o)
);
`default_nettype wire

// ==== gpp_pad_model.sv ====
`default_nettype none
module gpp_pad_model #(
   parameter int unsigned PINS = 32
) (
   input  wire logic [PINS-1:0] pin_out_i,
   input  wire logic [PINS-1:0] pin_oe_i,
   input  wire logic [PINS-1:0] ext_level_i,
   output logic      [PINS-1:0] pad_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // outside source always drives, so an undriven pad never floats
   assign pad_o = pin_oe_i & pin_out_i | ~pin_oe_i & ext_level_i;
endmodule : gpp_pad_model
`default_nettype wire

// ==== gpp_port_test.sv ====
`default_nettype none
module gpp_port_test
   import gpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0, ext = 32'h0, sd = 32'h4d6d1473, rdat, pout, poe, fsel, wake, pad;
   logic [31:0] fs = RST_ONES, ice = RST_ONES, arm = RST_ONES, oe = RST_ZERO, od = RST_ZERO;
   logic [31:0] md = RST_ZERO, pl = RST_ZERO, ien = RST_ZERO, pd = RST_ZERO, wk = RST_ZERO;
   logic [31:0] du = RST_ZERO, pv = RST_ZERO;
   int fails = 0, num_checks = 0;
   always #50 clk = ~clk;
   gpp_port i_gpp_port (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in_i(pad),
      .pin_out_o(pout), .pin_oe_o(poe), .function_select_o(fsel), .irq_o(irq), .wake_event_o(wake));
   gpp_pad_model i_gpp_pad_model (.pin_out_i(pout), .pin_oe_i(poe), .ext_level_i(ext), .pad_o(pad));
   ////////////////////////////////////////
   function automatic logic [31:0] xs();
      sd ^= sd << 13;
      sd ^= sd >> 17;
      sd ^= sd << 5;
      return sd;
   endfunction : xs
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic void mdl_wr(logic [7:0] a, logic [31:0] v, logic [31:0] m);
      case (a)
         OFS_FSEL: fs = fs & ~m | v;
         OFS_FSEL_SET: fs |= v;
         OFS_FSEL_CLR: fs &= ~v;
         OFS_OE: oe = oe & ~m | v;
         OFS_OE_SET: oe |= v;
         OFS_OE_CLR: oe &= ~v;
         OFS_OUT: od = od & ~m | v;
         OFS_OUT_SET: od |= v;
         OFS_OUT_CLR: od &= ~v;
         OFS_MODE: md = md & ~m | v;
         OFS_POL: pl = pl & ~m | v;
         OFS_INCON: ice = ice & ~m | v;
         OFS_IEN: ien = ien & ~m | v;
         OFS_IEN_SET: ien |= v;
         OFS_IEN_CLR: ien &= ~v;
         OFS_PEND_CLR: pd &= ~v;
         OFS_WAKE: wk = wk & ~m | v;
         OFS_WAKE_SET: wk |= v;
         OFS_WAKE_CLR: wk &= ~v;
         OFS_DUAL: du = du & ~m | v;
         default: ;
      endcase
      arm |= (a == OFS_PEND_CLR) ? v : RST_ZERO;
   endfunction : mdl_wr
   function automatic logic [31:0] mdl_rd(logic [7:0] a);
      case (a)
         OFS_FSEL: return fs;
         OFS_OE: return oe;
         OFS_OUT: return od;
         OFS_IN: return pv & ice;
         OFS_MODE: return md;
         OFS_POL: return pl;
         OFS_INCON: return ice;
         OFS_IEN: return ien;
         OFS_PEND: return pd;
         OFS_WAKE: return wk;
         OFS_DUAL: return du;
         default: return RST_ZERO;
      endcase
   endfunction : mdl_rd
   // five cycles covers sync, pending and irq stages
   task automatic settle();
      logic [31:0] nv, ev;
      repeat (5) @(posedge clk);
      nv = oe & od | ~oe & ext;
      ev = md & arm & (du & (nv ^ pv) | ~du & (pl & nv & ~pv | ~pl & pv & ~nv));
      pd |= ev | ~md & ~(nv ^ pl);
      arm &= ~ev;
      pv = nv;
      chk(poe, oe);
      chk(pout, od & oe);
      chk(fsel, fs);
      chk(wake, wk & md & pd);
      chk({31'h0, irq}, {31'h0, |(pd & ien)});
   endtask : settle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      logic [31:0] m;
      n = 0;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk({31'h0, ack}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (w)
         mdl_wr(a, d & m, m);
      else
         chk(rdat, mdl_rd(a));
      settle();
   endtask : wb
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      #3000000;
      fails++;
      end_of_test();
   end
   initial begin
      logic [31:0] r;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      settle();
      for (int i = 0; i < 32; i++)
         wb(1'b0, 8'(i * 4), xs(), 4'hf);
      $display("test reset_reads done");
      repeat (600) begin
         r = xs();
         if (r[1:0] == 2'h0) begin
            ext <= xs();
            settle();
         end else begin
            wb(r[2], {1'b0, r[7:3], 2'h0}, xs(), r[8] ? 4'hf : r[12:9]);
         end
      end
      $display("test random_traffic done");
      end_of_test();
   end
endmodule : gpp_port_test
`default_nettype wire
